// ### shared/adc_ref_pkg.sv
// Constants for the converter input select and reference control block
// What this block does
// R01 - Decode 6-bit code to pin, sensor, supply, ground
// R02 - Codes for P3.1-P3.7 need large package
// R03 - Software selects sensor code and enables sensor
// R04 - Sensor enable bit switches sensor on
// R05 - Source bit 0 routes reference pin
// R06 - Source bit 1 uses supply as reference
// R07 - Bias on whenever any consumer enabled
// R08 - Bias force-on bit ORs with consumer requests
// R09 - Buffer enable bit drives reference onto pin
// R10 - Software clears buffer enable when unused
// R11 - Software sets reference pin analog, skipped
// R12 - Reference control: four read-write bits, reset 0
// R13 - Select top bits read zero; reset selects ground
package adc_ref_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CHANNEL_SELECT_ADDR   = 8'hbb;
  localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hd1;
  localparam logic [7:0] CHANNEL_SELECT_RESET   = 8'h3f;
  localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CODE_WIDTH        = 6;
  localparam int REF_SRC_BIT       = 3;
  localparam int TEMP_EN_BIT       = 2;
  localparam int BIAS_FORCE_BIT    = 1;
  localparam int REF_BUF_BIT       = 0;

  // ****************************************
  // Select code boundaries
  // ****************************************
  localparam logic [5:0] CODE_LAST_PIN     = 6'h1f;
  localparam logic [5:0] CODE_LAST_SMALL   = 6'h18;
  localparam logic [5:0] CODE_TEMP_SENSOR  = 6'h30;
  localparam logic [5:0] CODE_SUPPLY       = 6'h31;
  localparam logic [5:0] CODE_FIRST_GROUND = 6'h32;

  typedef enum logic [2:0] {
    SRC_PIN,
    SRC_TEMP,
    SRC_SUPPLY,
    SRC_GROUND,
    SRC_NONE
  } input_source_t;

endpackage

// ### shared/mux_decode_if.sv
// Carrier between the register block and the input decoder
`timescale 1ns/1ps
interface mux_decode_if;
  import adc_ref_pkg::*;
  logic [5:0]    code;
  logic          large_package;
  input_source_t source;
  logic [4:0]    pin_index;
  modport regs (output code, output large_package, input source, input pin_index);
  modport dec  (input code, input large_package, output source, output pin_index);
endinterface

// ### design/input_code_decode.sv
// Combinational decode of the positive-input select code
`timescale 1ns/1ps
module input_code_decode
  import adc_ref_pkg::*;
(
  mux_decode_if.dec bus
);

  always_comb begin
    bus.pin_index = bus.code[4:0];
    if (bus.code <= CODE_LAST_PIN) begin
      // Pins missing on the small package connect to nothing
      if (!bus.large_package && bus.code > CODE_LAST_SMALL) begin // [R02]
        bus.source = SRC_NONE;
      end else begin
        bus.source = SRC_PIN; // [R01]
      end
    end else if (bus.code == CODE_TEMP_SENSOR) begin
      bus.source = SRC_TEMP; // [R01]
    end else if (bus.code == CODE_SUPPLY) begin
      bus.source = SRC_SUPPLY;
    end else if (bus.code >= CODE_FIRST_GROUND) begin
      bus.source = SRC_GROUND;
    end else begin
      // Reserved codes leave the mux open
      bus.source = SRC_NONE;
    end
  end

endmodule

// ### design/adc_input_and_reference_select.sv
// Register file and control outputs for converter input and reference selection
`timescale 1ns/1ps
module adc_input_and_reference_select
  import adc_ref_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Special-function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_we,
  output logic      [7:0] sfr_rdata,
  // Configuration strap and bias consumers
  input  wire logic       large_package,
  input  wire logic       converter_en,
  input  wire logic       oscillator_en,
  // Analog mux controls
  output logic      [4:0] mux_pin_index,
  output logic            mux_pin_sel,
  output logic            mux_temp_sel,
  output logic            mux_supply_sel,
  output logic            mux_ground_sel,
  // Reference and bias controls
  output logic            ref_from_supply,
  output logic            ref_from_pin,
  output logic            temp_sensor_on,
  output logic            bias_on,
  output logic            ref_buffer_on
);

  // ****************************************
  // Strap synchroniser
  // ****************************************
  // The package strap arrives from a pin, so it passes two flops first.
  // It only settles once at power-up, so the two extra cycles cost nothing.
  logic strap_meta_q;
  logic strap_meta_d;
  logic strap_sync_q;
  logic strap_sync_d;

  always_comb begin
    strap_meta_d = large_package;
    strap_sync_d = strap_meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Small package assumed until the strap has been seen
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
    end else begin
      strap_meta_q <= strap_meta_d;
      strap_sync_q <= strap_sync_d;
    end
  end

  // ****************************************
  // Channel select register
  // ****************************************
  logic [CODE_WIDTH-1:0] positive_input_code_q;
  logic [CODE_WIDTH-1:0] positive_input_code_d;
  logic                  sel_write;

  // Bits above the field are dropped on write, so they always read zero
  always_comb begin
    sel_write             = sfr_we && (sfr_addr == CHANNEL_SELECT_ADDR);
    positive_input_code_d = positive_input_code_q;
    if (sel_write) begin
      positive_input_code_d = sfr_wdata[CODE_WIDTH-1:0]; // [R13]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // All ones selects ground, so nothing live is measured before set-up
      positive_input_code_q <= CHANNEL_SELECT_RESET[CODE_WIDTH-1:0]; // [R13]
    end else begin
      positive_input_code_q <= positive_input_code_d;
    end
  end

  // ****************************************
  // Reference control register
  // ****************************************
  logic [3:0] reference_control_q;
  logic [3:0] reference_control_d;
  logic       ref_write;

  // Only the four low bits are stored; the upper nibble is ignored
  always_comb begin
    ref_write           = sfr_we && (sfr_addr == REFERENCE_CONTROL_ADDR);
    reference_control_d = reference_control_q;
    if (ref_write) begin
      reference_control_d = sfr_wdata[3:0]; // [R12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_control_q <= REFERENCE_CONTROL_RESET[3:0]; // [R12]
    end else begin
      reference_control_q <= reference_control_d;
    end
  end

  // ****************************************
  // Input decode
  // ****************************************
  mux_decode_if dec_bus ();
  assign dec_bus.code          = positive_input_code_q;
  assign dec_bus.large_package = strap_sync_q; // [R02]

  input_code_decode u_decode (
    .bus (dec_bus)
  );

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_d;

  // Registered read port: data follows the address by one cycle
  always_comb begin
    case (sfr_addr)
      CHANNEL_SELECT_ADDR: begin
        rdata_d = {2'h0, positive_input_code_q}; // [R13]
      end
      REFERENCE_CONTROL_ADDR: begin
        rdata_d = {4'h0, reference_control_q}; // [R12]
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_d;
    end
  end

  // ****************************************
  // Analog mux selects
  // ****************************************
  logic [4:0] pin_index_d;
  logic       pin_sel_d;
  logic       temp_sel_d;
  logic       supply_sel_d;
  logic       ground_sel_d;

  // One-hot selects; reserved codes and missing pins leave all of them low
  always_comb begin
    pin_index_d  = dec_bus.pin_index;
    pin_sel_d    = (dec_bus.source == SRC_PIN); // [R01] [R02]
    temp_sel_d   = (dec_bus.source == SRC_TEMP); // [R01]
    supply_sel_d = (dec_bus.source == SRC_SUPPLY); // [R01]
    ground_sel_d = (dec_bus.source == SRC_GROUND); // [R01]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Matches the reset code, which selects ground
      mux_pin_index  <= 5'h00;
      mux_pin_sel    <= 1'b0;
      mux_temp_sel   <= 1'b0;
      mux_supply_sel <= 1'b0;
      mux_ground_sel <= 1'b1;
    end else begin
      mux_pin_index  <= pin_index_d;
      mux_pin_sel    <= pin_sel_d;
      mux_temp_sel   <= temp_sel_d;
      mux_supply_sel <= supply_sel_d;
      mux_ground_sel <= ground_sel_d;
    end
  end

  // ****************************************
  // Reference source
  // ****************************************
  logic ref_supply_d;
  logic ref_pin_d;

  // Exactly one of the two reference paths is closed at any time
  always_comb begin
    ref_supply_d = reference_control_q[REF_SRC_BIT]; // [R06]
    ref_pin_d    = !reference_control_q[REF_SRC_BIT]; // [R05]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_from_supply <= 1'b0;
      ref_from_pin    <= 1'b1;
    end else begin
      ref_from_supply <= ref_supply_d;
      ref_from_pin    <= ref_pin_d;
    end
  end

  // ****************************************
  // Sensor, bias and buffer
  // ****************************************
  logic temp_on_d;
  logic bias_request;
  logic bias_d;
  logic buf_d;

  always_comb begin
    // Converter, sensor and oscillator each need the bias; any one of them
    // turns it on, whatever the manual bit holds
    bias_request = converter_en | oscillator_en | reference_control_q[TEMP_EN_BIT]; // [R07]
    temp_on_d    = reference_control_q[TEMP_EN_BIT]; // [R04]
    bias_d       = reference_control_q[BIAS_FORCE_BIT] | bias_request; // [R08]
    buf_d        = reference_control_q[REF_BUF_BIT]; // [R09]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_sensor_on <= 1'b0;
      bias_on        <= 1'b0;
      ref_buffer_on  <= 1'b0;
    end else begin
      temp_sensor_on <= temp_on_d;
      bias_on        <= bias_d;
      ref_buffer_on  <= buf_d;
    end
  end

endmodule

// ### test/adc_sel_properties.sv
// Port-level checker for converter input and reference select
`timescale 1ns/1ps
module adc_sel_properties (
  // Clock, reset and register bus
  input logic       clk,
  input logic       rst_n,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_wdata,
  input logic       sfr_we,
  input logic [7:0] sfr_rdata,
  // Strap, consumers and controls
  input logic       large_package,
  input logic       converter_en,
  input logic       oscillator_en,
  input logic [4:0] mux_pin_index,
  input logic       mux_pin_sel,
  input logic       mux_temp_sel,
  input logic       mux_supply_sel,
  input logic       mux_ground_sel,
  input logic       ref_from_supply,
  input logic       ref_from_pin,
  input logic       temp_sensor_on,
  input logic       bias_on,
  input logic       ref_buffer_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr_sel = sfr_we && sfr_addr == 8'hbb;
  wire wr_ref = sfr_we && sfr_addr == 8'hd1;
  property p_src; wr_ref |-> ##2 ref_from_supply == $past(sfr_wdata[3], 2) && ref_from_pin != ref_from_supply; endproperty
  a_src: assert property (p_src) else $error("ref source");
  property p_temp; wr_ref |-> ##2 temp_sensor_on == $past(sfr_wdata[2], 2); endproperty
  a_temp: assert property (p_temp) else $error("sensor enable");
  property p_buf; wr_ref |-> ##2 ref_buffer_on == $past(sfr_wdata[0], 2); endproperty
  a_buf: assert property (p_buf) else $error("ref buffer");
  property p_cons; converter_en || oscillator_en |=> bias_on; endproperty
  a_cons: assert property (p_cons) else $error("bias consumer");
  property p_force; wr_ref && sfr_wdata[1] |-> ##2 bias_on; endproperty
  a_force: assert property (p_force) else $error("bias force");
  property p_dec; wr_sel |-> ##2 mux_pin_index == $past(sfr_wdata[4:0], 2)
    && mux_ground_sel == ($past(sfr_wdata[5:0], 2) > 6'h31); endproperty
  a_dec: assert property (p_dec) else $error("decode");
  property p_pkg; !large_package ##1 (wr_sel && sfr_wdata[5:0] > 6'h18 && sfr_wdata[5:0] < 6'h20)
    |-> ##2 !mux_pin_sel; endproperty
  a_pkg: assert property (p_pkg) else $error("package pin");
  property p_rd; sfr_addr == 8'hbb |=> sfr_rdata[7:6] == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("select top bits");
endmodule
bind adc_input_and_reference_select adc_sel_properties adc_sel_properties_i (.*);

// ### test/tb.sv
// Self-checking bench for converter input and reference select
`timescale 1ns/1ps
module tb;
  logic        clk = 1'h0, rst_n = 1'h0, sfr_we = 1'h0, chk = 1'h0;
  logic        large_package = 1'h0, converter_en = 1'h0, oscillator_en = 1'h0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, r;
  wire  [13:0] o;
  logic [21:0] e;
  logic [21:0] q[$];
  int          errors = 0, n_tests = 0;
  adc_input_and_reference_select adc_input_and_reference_select_i (.*, .mux_pin_index(o[13:9]),
    .mux_pin_sel(o[8]), .mux_temp_sel(o[7]), .mux_supply_sel(o[6]), .mux_ground_sel(o[5]),
    .ref_from_supply(o[4]), .ref_from_pin(o[3]), .temp_sensor_on(o[2]), .bias_on(o[1]), .ref_buffer_on(o[0]));
  initial forever #4 clk = ~clk;
  // Expected outputs and read data for a given register state
  function automatic logic [21:0] ex(logic [7:0] a, logic [5:0] c, logic [3:0] w);
    return {c[4:0], c < 6'h19 || (c < 6'h20 && large_package), c == 6'h30, c == 6'h31, c > 6'h31,
      w[3], !w[3], w[2], |{w[2:1], converter_en, oscillator_en}, w[0],
      a == 8'hbb ? {2'h0, c} : a == 8'hd1 ? {4'h0, w} : 8'h00};
  endfunction
  // Strobe stays up across back-to-back writes; the next read lowers it.
  // Checking pauses while writing, since writes queue no expectation.
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'h1;
    chk = 1'h0;
  endtask
  task rd(logic [7:0] a, logic [5:0] c, logic [3:0] w);
    @(negedge clk);
    sfr_addr = a;
    sfr_we = 1'h0;
    chk = 1'h1;
    q.push_back(ex(a, c, w));
  endtask
  task conclude;
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) if (chk) begin
    #1;
    e = q.pop_front();
    n_tests++;
    if ({o, sfr_rdata} !== e) begin
      errors++;
      $display("Error %0t expected %h got %h", $time, e, {o, sfr_rdata});
    end
  end
  initial begin
    #100000;
    errors++;
    conclude;
  end
  initial begin
    void'($urandom(22));
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'h1;
    rd(8'hbb, 6'h3f, 4'h0);
    rd(8'hd1, 6'h3f, 4'h0);
    // Every code, with and without the large package
    for (int i = 0; i < 128; i++) begin
      r = 8'($urandom);
      // Software keeps the sensor on while it is measured
      if (6'(i) == 6'h30) r[2] = 1'h1;
      // and the reference buffer off while the supply is the reference
      if (r[3]) r[0] = 1'h0;
      wr(8'hbb, {r[7:6], 6'(i)});
      large_package = i[6];
      converter_en = r[4];
      oscillator_en = r[5];
      wr(8'hd1, r);
      rd(8'hbb, 6'(i), r[3:0]);
      rd(8'hd1, 6'(i), r[3:0]);
      rd({1'h0, r[6:0]}, 6'(i), r[3:0]);
    end
    @(negedge clk) chk = 1'h0;
    conclude;
  end
endmodule
